// ---- verilog/dtc_timer_pair.v ----
// Purpose: two 16-bit timer/counters with four modes and overflow toggle outputs
// Assumes: software bits arrive as plain ports on clk; pins are asynchronous
// Notes:   count bytes and flags are outputs straight from their registers
`timescale 1ns/1ps
`include "dtc_consts.vh"

// ==========================================================
// pin synchroniser with agreement filter
// ==========================================================
module dtc_pin_sync (
  // clock and reset
  input  wire clk,
  input  wire nrst,
  // pin and filtered level
  input  wire pin,
  output reg  level
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= `DTC_PIN_IDLE;
      s2_reg <= `DTC_PIN_IDLE;
      s3_reg <= `DTC_PIN_IDLE;
      level  <= `DTC_PIN_IDLE;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // change accepted once second and third stages agree
      if (s2_reg == s3_reg) begin
        level <= s3_reg;
      end
    end
  end

endmodule // dtc_pin_sync

// ==========================================================
// timer/counter pair
// ==========================================================
module dtc_timer_pair (
  // clock and reset
  input  wire       clk,
  input  wire       nrst,
  // configuration
  input  wire [7:0] timer_mode_register,
  input  wire       timer_zero_run,
  input  wire       timer_one_run,
  input  wire       timer_zero_speed_select,
  input  wire       timer_one_speed_select,
  input  wire       toggle_enable_zero,
  input  wire       toggle_enable_one,
  // count byte writes
  input  wire [7:0] count_wdata,
  input  wire       timer_zero_low_byte_wr,
  input  wire       timer_zero_high_byte_wr,
  input  wire       timer_one_low_byte_wr,
  input  wire       timer_one_high_byte_wr,
  // flag clears
  input  wire       timer_zero_overflow_clr,
  input  wire       timer_one_overflow_clr,
  // count bytes and flags
  output reg  [7:0] timer_zero_low_byte,
  output reg  [7:0] timer_zero_high_byte,
  output reg  [7:0] timer_one_low_byte,
  output reg  [7:0] timer_one_high_byte,
  output reg        timer_zero_overflow,
  output reg        timer_one_overflow,
  // gate pins
  input  wire       gate_pin_zero,
  input  wire       gate_pin_one,
  // count pins
  input  wire       count_pin_zero_in,
  output reg        count_pin_zero_out,
  output reg        count_pin_zero_oe,
  input  wire       count_pin_one_in,
  output reg        count_pin_one_out,
  output reg        count_pin_one_oe
);

  // ========================================================
  // mode register fields
  // ========================================================
  wire [1:0] mode0;
  wire [1:0] mode1;
  wire       ct0;
  wire       ct1;
  wire       gate0;
  wire       gate1;
  wire       split0;

  assign mode0  = {timer_mode_register[`DTC_MODE0_HI], timer_mode_register[`DTC_MODE0_LO]}; // [RULE6]
  assign mode1  = {timer_mode_register[`DTC_MODE1_HI], timer_mode_register[`DTC_MODE1_LO]}; // [RULE6]
  assign ct0    = timer_mode_register[`DTC_CT0];   // [RULE5]
  assign ct1    = timer_mode_register[`DTC_CT1];   // [RULE5]
  assign gate0  = timer_mode_register[`DTC_GATE0];
  assign gate1  = timer_mode_register[`DTC_GATE1];
  assign split0 = (mode0 == `DTC_MODE_SPLIT);

  // ========================================================
  // pin synchronisers
  // ========================================================
  wire gate0_lvl;
  wire gate1_lvl;
  wire cnt0_lvl;
  wire cnt1_lvl;

  dtc_pin_sync u_sync_gate0 (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (gate_pin_zero),
    .level (gate0_lvl)
  );

  dtc_pin_sync u_sync_gate1 (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (gate_pin_one),
    .level (gate1_lvl)
  );

  dtc_pin_sync u_sync_cnt0 (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (count_pin_zero_in),
    .level (cnt0_lvl)
  );

  dtc_pin_sync u_sync_cnt1 (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (count_pin_one_in),
    .level (cnt1_lvl)
  );

  // ========================================================
  // machine cycle phases and time base
  // ========================================================
  reg  [1:0] phase_reg;
  reg  [1:0] slow_reg;
  wire       at_c3;
  wire       at_c4;
  wire       slow_due;
  wire       tick0;
  wire       tick1;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 2'h0;
      slow_reg  <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == `DTC_PH_LAST) begin
        slow_reg <= (slow_reg == `DTC_SLOW_LAST) ? 2'h0 : slow_reg + 2'h1;
      end
    end
  end

  assign at_c3    = (phase_reg == `DTC_PH_C3);  // [RULE3]
  assign at_c4    = (phase_reg == `DTC_PH_C4);  // [RULE2]
  assign slow_due = (slow_reg == `DTC_SLOW_LAST);
  // one tick per machine cycle or per three machine cycles
  assign tick0    = at_c3 & (timer_zero_speed_select | slow_due); // [RULE1] [RULE8]
  assign tick1    = at_c3 & (timer_one_speed_select | slow_due);  // [RULE1] [RULE8]

  // ========================================================
  // count pin edge detection
  // ========================================================
  reg samp0_reg;
  reg samp1_reg;
  reg edge0_reg;
  reg edge1_reg;

  // sample at c4, edge held until the next c4 so next c3 consumes it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      samp0_reg <= `DTC_PIN_IDLE;
      samp1_reg <= `DTC_PIN_IDLE;
      edge0_reg <= 1'b0;
      edge1_reg <= 1'b0;
    end else if (at_c4) begin
      samp0_reg <= cnt0_lvl;              // [RULE2]
      samp1_reg <= cnt1_lvl;              // [RULE2]
      edge0_reg <= samp0_reg & ~cnt0_lvl; // [RULE2] [RULE4]
      edge1_reg <= samp1_reg & ~cnt1_lvl; // [RULE2] [RULE4]
    end
  end

  // ========================================================
  // count enables
  // ========================================================
  wire en0;
  wire en1;
  wire inc0;
  wire inc1;
  wire inc_hi0;

  assign en0     = timer_zero_run & (~gate0 | gate0_lvl);              // [RULE7] [RULE13]
  assign en1     = (split0 | timer_one_run) & (~gate1 | gate1_lvl);    // [RULE7] [RULE15]
  assign inc0    = en0 & (ct0 ? edge0_reg & at_c3 : tick0);            // [RULE3]
  assign inc1    = en1 & (ct1 ? edge1_reg & at_c3 : tick1);            // [RULE3]
  assign inc_hi0 = split0 & timer_one_run & tick0;                     // [RULE14]

  // ========================================================
  // one count step: returns {overflow, high, low}
  // ========================================================
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] hi;
    input [7:0] lo;
    reg   [12:0] c13;
    reg   [15:0] c16;
    begin
      c13      = {hi, lo[4:0]} + 13'h1;
      c16      = {hi, lo} + 16'h1;
      dtc_step = {1'b0, hi, lo};
      case (mode)
        `DTC_MODE_13: begin
          // top three low bits held
          dtc_step = {({hi, lo[4:0]} == `DTC_MAX_13), c13[12:5], lo[7:5], c13[4:0]}; // [RULE9]
        end
        `DTC_MODE_16: begin
          dtc_step = {({hi, lo} == `DTC_MAX_16), c16}; // [RULE10]
        end
        `DTC_MODE_RELOAD: begin
          if (lo == `DTC_MAX_8) begin
            dtc_step = {1'b1, hi, hi}; // [RULE11]
          end else begin
            dtc_step = {1'b0, hi, c16[7:0]};
          end
        end
        `DTC_MODE_SPLIT: begin
          // plain 8-bit low byte, high byte left alone
          dtc_step = {(lo == `DTC_MAX_8), hi, c16[7:0]}; // [RULE13]
        end
        default: begin
          dtc_step = {1'b0, hi, lo};
        end
      endcase
    end
  endfunction

  // ========================================================
  // next count values
  // ========================================================
  reg  [7:0] zero_low_next;
  reg  [7:0] zero_high_next;
  reg  [7:0] one_low_next;
  reg  [7:0] one_high_next;
  reg        ovf0;
  reg        ovf1;
  reg        ovf_hi0;
  reg [16:0] step0;
  reg [16:0] step1;

  always @* begin
    step0    = dtc_step(mode0, timer_zero_high_byte, timer_zero_low_byte);
    step1    = dtc_step(mode1, timer_one_high_byte, timer_one_low_byte);
    zero_low_next  = timer_zero_low_byte;
    zero_high_next = timer_zero_high_byte;
    one_low_next   = timer_one_low_byte;
    one_high_next  = timer_one_high_byte;
    ovf0           = 1'b0;
    ovf1           = 1'b0;
    ovf_hi0        = 1'b0;
    if (inc0) begin
      zero_low_next = step0[7:0];
      ovf0          = step0[16];
      if (!split0) begin
        zero_high_next = step0[15:8];
      end
    end
    if (inc_hi0) begin
      zero_high_next = timer_zero_high_byte + 8'h1;            // [RULE14]
      ovf_hi0        = (timer_zero_high_byte == `DTC_MAX_8);  // [RULE14]
    end
    // mode 3 freezes timer one
    if (inc1 && (mode1 != `DTC_MODE_SPLIT)) begin             // [RULE12]
      one_low_next  = step1[7:0];
      one_high_next = step1[15:8];
      ovf1          = step1[16];
    end
    // software write wins over a step in the same cycle
    if (timer_zero_low_byte_wr) begin
      zero_low_next = count_wdata;                            // [RULE18]
    end
    if (timer_zero_high_byte_wr) begin
      zero_high_next = count_wdata;                           // [RULE18]
    end
    if (timer_one_low_byte_wr) begin
      one_low_next = count_wdata;                             // [RULE18]
    end
    if (timer_one_high_byte_wr) begin
      one_high_next = count_wdata;                            // [RULE18]
    end
  end

  // ========================================================
  // flag sources
  // ========================================================
  wire set_flag0;
  wire set_flag1;
  wire flip0;
  wire flip1;

  assign set_flag0 = ovf0;                            // [RULE17]
  assign set_flag1 = split0 ? ovf_hi0 : ovf1;         // [RULE14] [RULE15] [RULE17]
  assign flip0     = ovf0 & toggle_enable_zero & ~ct0; // [RULE16]
  assign flip1     = ovf1 & toggle_enable_one & ~ct1;  // [RULE16]

  // ========================================================
  // registers
  // ========================================================
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_zero_low_byte  <= `DTC_BYTE_RST;
      timer_zero_high_byte <= `DTC_BYTE_RST;
      timer_one_low_byte   <= `DTC_BYTE_RST;
      timer_one_high_byte  <= `DTC_BYTE_RST;
      timer_zero_overflow  <= 1'b0;
      timer_one_overflow   <= 1'b0;
      count_pin_zero_out   <= `DTC_PIN_IDLE;
      count_pin_one_out    <= `DTC_PIN_IDLE;
      count_pin_zero_oe    <= 1'b0;
      count_pin_one_oe     <= 1'b0;
    end else begin
      timer_zero_low_byte  <= zero_low_next;
      timer_zero_high_byte <= zero_high_next;
      timer_one_low_byte   <= one_low_next;
      timer_one_high_byte  <= one_high_next;
      // set wins over a clear in the same cycle
      timer_zero_overflow  <= set_flag0 | (timer_zero_overflow & ~timer_zero_overflow_clr);
      timer_one_overflow   <= set_flag1 | (timer_one_overflow & ~timer_one_overflow_clr);
      count_pin_zero_out   <= count_pin_zero_out ^ flip0;  // [RULE16]
      count_pin_one_out    <= count_pin_one_out ^ flip1;   // [RULE16]
      count_pin_zero_oe    <= toggle_enable_zero & ~ct0;   // [RULE16]
      count_pin_one_oe     <= toggle_enable_one & ~ct1;    // [RULE16]
    end
  end

endmodule // dtc_timer_pair

// ---- verilog/dtc_consts.vh ----
// Purpose: constants for the dual timer/counter pair
// Assumes: four clock phases per machine cycle, C1 first
// Notes:   included by dtc_timer_pair.v only
//
// Notes on behaviour
// RULE1: timer function advances at one twelfth or one quarter clock; speed bit zero is twelfth.
// RULE2: count pin sampled once per machine cycle at C4; high then low is an edge.
// RULE3: counts update at C3; a detected edge counts in the following machine cycle.
// RULE4: edge detection spans two machine cycles, so pin counting tops out at clock/8.
// RULE5: mode register bit 2 and bit 6 choose timing (0) or pin counting (1).
// RULE6: each timer has a two-bit mode field choosing one of four modes.
// RULE7: a timer counts only when run is set and gate is zero or gate pin high.
// RULE8: in timing function the counter steps on each prescaled time base tick.
// RULE9: mode 0 is 13 bits, high byte plus low five; flag set from 1fff to 0000.
// RULE10: mode 1 is 16 bits; overflow flag set rolling from ffff to 0000.
// RULE11: mode 2 low byte counts, reloads from high byte on ff to 00, sets flag.
// RULE12: timer one in mode 3 freezes and holds its count.
// RULE13: timer zero mode 3 low byte is an 8-bit counter with timer zero controls.
// RULE14: timer zero mode 3 high byte counts clock ticks, uses timer one run and flag.
// RULE15: with timer zero split, timer one runs without run bit or flag; mode 3 stops it.
// RULE16: in timing function, toggle enable inverts the count pin output on every overflow.
// RULE17: overflow flags are set at C3 of the machine cycle that overflows.
// RULE18: count bytes are readable and writable anytime; writes count on from next C3.
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// machine cycle phases
`define DTC_PH_C3        2'h2
`define DTC_PH_C4        2'h3
`define DTC_PH_LAST      2'h3
// slow time base: three machine cycles per tick (clock/12)
`define DTC_SLOW_LAST    2'h2

// mode register field positions
`define DTC_MODE0_LO     0
`define DTC_MODE0_HI     1
`define DTC_CT0          2
`define DTC_GATE0        3
`define DTC_MODE1_LO     4
`define DTC_MODE1_HI     5
`define DTC_CT1          6
`define DTC_GATE1        7

// operating modes
`define DTC_MODE_13      2'h0
`define DTC_MODE_16      2'h1
`define DTC_MODE_RELOAD  2'h2
`define DTC_MODE_SPLIT   2'h3

// limits and reset values
`define DTC_MAX_13       13'h1fff
`define DTC_MAX_16       16'hffff
`define DTC_MAX_8        8'hff
`define DTC_BYTE_RST     8'h00
`define DTC_PIN_IDLE     1'b1

`endif

// ---- dv/dtc_timer_pair_props.sv ----
// Purpose: checker for the timer/counter pair, bound to its top module
// Assumes: one clock domain, async active-low reset
// Notes:   watches a subset of the top ports
`timescale 1ns/1ps
module dtc_timer_pair_props (
  // clock and reset
  input wire       clk,
  input wire       nrst,
  // configuration
  input wire [7:0] timer_mode_register,
  input wire       timer_zero_run,
  input wire       toggle_enable_zero,
  // writes and clears
  input wire [7:0] count_wdata,
  input wire       timer_zero_low_byte_wr,
  input wire       timer_zero_high_byte_wr,
  input wire       timer_one_low_byte_wr,
  input wire       timer_one_high_byte_wr,
  input wire       timer_zero_overflow_clr,
  // counts, flags, pin
  input wire [7:0] timer_zero_low_byte,
  input wire [7:0] timer_zero_high_byte,
  input wire [7:0] timer_one_low_byte,
  input wire [7:0] timer_one_high_byte,
  input wire       timer_zero_overflow,
  input wire       count_pin_zero_out,
  input wire       count_pin_zero_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // assertions
  // ==========================================================
  a_write_lands_high: assert property (timer_zero_high_byte_wr |=>
    timer_zero_high_byte == $past(count_wdata)) else $error("high byte write lost");
  a_halt_holds_count: assert property (!timer_zero_run && timer_mode_register[1:0] != 2'h3
    && !timer_zero_low_byte_wr && !timer_zero_high_byte_wr
    |=> $stable({timer_zero_high_byte, timer_zero_low_byte})) else $error("stopped timer moved");
  a_frozen_one_holds: assert property (timer_mode_register[5:4] == 2'h3
    && !timer_one_low_byte_wr && !timer_one_high_byte_wr
    |=> $stable({timer_one_high_byte, timer_one_low_byte})) else $error("frozen timer moved");
  a_step_spacing: assert property ((timer_zero_low_byte != $past(timer_zero_low_byte))
    && !$past(timer_zero_low_byte_wr) |=> ($stable(timer_zero_low_byte)
    || $past(timer_zero_low_byte_wr)) [*3]) else $error("steps closer than a machine cycle");
  a_ovf_toggles_pin: assert property ($rose(timer_zero_overflow) && toggle_enable_zero
    && !timer_mode_register[2] |-> count_pin_zero_out != $past(count_pin_zero_out))
    else $error("pin did not toggle on overflow");
  a_oe_follows: assert property (count_pin_zero_oe ==
    $past(toggle_enable_zero && !timer_mode_register[2])) else $error("pin enable wrong");
  a_wrap_sets_flag: assert property ($past(timer_mode_register[1:0]) == 2'h1
    && $past({timer_zero_high_byte, timer_zero_low_byte}) == 16'hffff
    && {timer_zero_high_byte, timer_zero_low_byte} == 16'h0000
    && !$past(timer_zero_low_byte_wr || timer_zero_high_byte_wr) |-> timer_zero_overflow)
    else $error("wrap without flag");
  a_reload_keeps: assert property ($past(timer_mode_register[5:4]) == 2'h2
    && $past(timer_one_low_byte) == 8'hff && timer_one_low_byte != 8'hff
    && !$past(timer_one_low_byte_wr || timer_one_high_byte_wr)
    |-> timer_one_low_byte == $past(timer_one_high_byte) && $stable(timer_one_high_byte))
    else $error("reload wrong");
  a_flag_sticky: assert property ($fell(timer_zero_overflow) |->
    $past(timer_zero_overflow_clr)) else $error("flag dropped without clear");
endmodule // dtc_timer_pair_props

bind dtc_timer_pair dtc_timer_pair_props u_props (.*);

// ---- dv/dtc_pin_partner.sv ----
// Purpose: external source on one count pin
// Assumes: pin pulled high when nobody drives it
// Notes:   pulses are 8 clocks low, 8 high
`timescale 1ns/1ps
module dtc_pin_partner (
  // clock
  input  wire clk,
  // design side of the pin
  input  wire drive_out,
  input  wire drive_oe,
  // resolved pin level
  output wire pin
);
  reg level_reg = 1'b1;
  // design output wins while enabled
  assign pin = drive_oe ? drive_out : level_reg;
  // each level held two machine cycles: rate clk/16
  task pulses(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        repeat (8) @(negedge clk);
        level_reg = 1'b0;
        repeat (8) @(negedge clk);
        level_reg = 1'b1;
      end
    end
  endtask
endmodule // dtc_pin_partner

// ---- dv/dtc_timer_pair_test.sv ----
// Purpose: self-checking bench for the timer/counter pair
// Assumes: inputs driven at falling clock edges
// Notes:   flags measured at falling edges, so spacing is exact
`timescale 1ns/1ps
module dtc_timer_pair_test;
  reg        clk = 1'b0;
  reg        nrst = 1'b0;
  reg  [7:0] timer_mode_register = 8'h00;
  reg        timer_zero_run = 1'b0;
  reg        timer_one_run = 1'b0;
  reg        timer_zero_speed_select = 1'b1;
  reg        timer_one_speed_select = 1'b0;
  reg        toggle_enable_zero = 1'b0;
  reg        toggle_enable_one = 1'b0;
  reg  [7:0] count_wdata = 8'h00;
  reg  [3:0] wsel = 4'h0;
  reg        timer_zero_overflow_clr = 1'b0;
  reg        timer_one_overflow_clr = 1'b0;
  reg        gate_pin_zero = 1'b0;
  reg        gate_pin_one = 1'b1;
  wire       timer_zero_low_byte_wr = wsel[0];
  wire       timer_zero_high_byte_wr = wsel[1];
  wire       timer_one_low_byte_wr = wsel[2];
  wire       timer_one_high_byte_wr = wsel[3];
  wire [7:0] timer_zero_low_byte;
  wire [7:0] timer_zero_high_byte;
  wire [7:0] timer_one_low_byte;
  wire [7:0] timer_one_high_byte;
  wire       timer_zero_overflow;
  wire       timer_one_overflow;
  wire       count_pin_zero_in;
  wire       count_pin_zero_out;
  wire       count_pin_zero_oe;
  wire       count_pin_one_in;
  wire       count_pin_one_out;
  wire       count_pin_one_oe;
  integer    err_total = 0;
  integer    num_checks = 0;
  integer    k;
  time       ta;
  time       tb;
  time       dt;

  always #2 clk = ~clk;

  dtc_timer_pair DUT (.*);
  dtc_pin_partner pp0 (.clk(clk), .drive_out(count_pin_zero_out),
    .drive_oe(count_pin_zero_oe), .pin(count_pin_zero_in));
  dtc_pin_partner pp1 (.clk(clk), .drive_out(count_pin_one_out),
    .drive_oe(count_pin_one_oe), .pin(count_pin_one_in));

  // ==========================================================
  // tasks
  // ==========================================================
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // sel: 0 t0 low, 1 t0 high, 2 t1 low, 3 t1 high
  task wr(input [1:0] sel, input [7:0] d);
    begin
      @(negedge clk);
      count_wdata = d;
      wsel = 4'h1 << sel;
      @(negedge clk);
      wsel = 4'h0;
    end
  endtask
  // wait for a flag, note when, then clear it
  task wflag(input s, output time t);
    integer i;
    reg     hit;
    begin
      hit = 1'b0;
      for (i = 0; i < 3000 && !hit; i = i + 1) begin
        @(negedge clk);
        if ((s ? timer_one_overflow : timer_zero_overflow) === 1'b1) hit = 1'b1;
      end
      t = $time;
      if (!hit) begin
        err_total = err_total + 1;
        complete_run;
      end else begin
        if (s) timer_one_overflow_clr = 1'b1;
        else timer_zero_overflow_clr = 1'b1;
        @(negedge clk);
        timer_one_overflow_clr = 1'b0;
        timer_zero_overflow_clr = 1'b0;
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask

  // ==========================================================
  // main sequence
  // ==========================================================
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk({timer_zero_high_byte, timer_zero_low_byte}, 16'h0000);
    chk({timer_one_high_byte, timer_one_low_byte}, 16'h0000);
    chk({timer_zero_overflow, timer_one_overflow, count_pin_zero_out, count_pin_one_out,
         count_pin_zero_oe, count_pin_one_oe}, 16'h000c);
    // 16-bit wrap with toggle
    timer_mode_register = 8'h01;
    toggle_enable_zero = 1'b1;
    wr(1, 8'hff);
    wr(0, 8'hfe);
    timer_zero_run = 1'b1;
    wflag(0, ta);
    timer_zero_run = 1'b0;
    chk({timer_zero_high_byte, timer_zero_low_byte}, 16'h0000);
    chk({count_pin_zero_out, count_pin_zero_oe}, 16'h0001);
    // 13-bit wrap keeps low byte top bits
    timer_mode_register = 8'h00;
    wr(1, 8'hff);
    wr(0, 8'hff);
    timer_zero_run = 1'b1;
    wflag(0, ta);
    timer_zero_run = 1'b0;
    chk({timer_zero_high_byte, timer_zero_low_byte}, 16'h00e0);
    chk(count_pin_zero_out, 16'h0001);
    // reload period at both rates
    timer_mode_register = 8'h20;
    toggle_enable_one = 1'b1;
    wr(3, 8'hfe);
    wr(2, 8'hfe);
    for (k = 1; k >= 0; k = k - 1) begin
      timer_one_speed_select = k[0];
      timer_one_run = 1'b1;
      wflag(1, ta);
      chk({count_pin_one_out, count_pin_one_oe}, 16'h0001);
      wflag(1, tb);
      dt = (tb - ta) / 4;
      chk(dt[15:0], k ? 16'h0008 : 16'h0018);
      chk(timer_one_high_byte, 16'h00fe);
    end
    timer_one_run = 1'b0;
    // gate pin
    timer_mode_register = 8'h09;
    wr(1, 8'h00);
    wr(0, 8'h00);
    timer_zero_run = 1'b1;
    repeat (40) @(negedge clk);
    chk({timer_zero_high_byte, timer_zero_low_byte}, 16'h0000);
    gate_pin_zero = 1'b1;
    repeat (40) @(negedge clk);
    chk(timer_zero_low_byte > 8'h08 && timer_zero_low_byte < 8'h0c, 16'h0001);
    timer_zero_run = 1'b0;
    // pin counting
    timer_mode_register = 8'h05;
    wr(1, 8'h00);
    wr(0, 8'h00);
    timer_zero_run = 1'b1;
    pp0.pulses(5);
    repeat (20) @(negedge clk);
    chk({timer_zero_high_byte, timer_zero_low_byte}, 16'h0005);
    chk(count_pin_zero_oe, 16'h0000);
    timer_zero_run = 1'b0;
    // timer one pin counting under its gate pin
    timer_mode_register = 8'hd0;
    wr(3, 8'h00);
    wr(2, 8'h00);
    timer_one_run = 1'b1;
    pp1.pulses(3);
    repeat (20) @(negedge clk);
    chk({timer_one_high_byte, timer_one_low_byte}, 16'h0003);
    chk(count_pin_one_oe, 16'h0000);
    gate_pin_one = 1'b0;
    pp1.pulses(2);
    repeat (20) @(negedge clk);
    chk({timer_one_high_byte, timer_one_low_byte}, 16'h0003);
    timer_one_run = 1'b0;
    // split timer zero, frozen timer one
    timer_mode_register = 8'h33;
    wr(3, 8'h12);
    wr(2, 8'h34);
    wr(1, 8'hfe);
    wr(0, 8'hf0);
    timer_one_run = 1'b1;
    wflag(1, ta);
    chk({timer_zero_high_byte, timer_zero_low_byte}, 16'h00f0);
    chk({timer_one_high_byte, timer_one_low_byte}, 16'h1234);
    chk(timer_zero_overflow, 16'h0000);
    wr(0, 8'hff);
    timer_zero_run = 1'b1;
    wflag(0, ta);
    chk(timer_zero_low_byte, 16'h0000);
    // timer one runs without its run bit or flag
    timer_mode_register = 8'h23;
    timer_one_run = 1'b0;
    timer_zero_run = 1'b0;
    wr(2, 8'hfe);
    repeat (80) @(negedge clk);
    chk(timer_one_overflow, 16'h0000);
    chk(timer_one_low_byte > 8'h11 && timer_one_low_byte < 8'h20, 16'h0001);
    complete_run;
  end
endmodule // dtc_timer_pair_test
